// File: bus_matrix_pkg.sv
package bus_matrix_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_SLAVES = 5;
    localparam int NUM_APB_SLOTS = 16;

    // slave port indices
    localparam int PORT_FLASH = 0;
    localparam int PORT_SRAM = 1;
    localparam int PORT_ADC = 2;
    localparam int PORT_AHB = 3;
    localparam int PORT_APB = 4;

    // address regions
    localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
    localparam logic [31:0] BOOT_LAST = 32'h0000_75ff;
    localparam logic [31:0] FLASH_BASE = 32'h0800_0000;
    localparam logic [31:0] FLASH_LAST = 32'h0800_75ff;
    localparam logic [31:0] INFO_BASE = 32'h1fff_f000;
    localparam logic [31:0] INFO_LAST = 32'h1fff_f60f;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_LAST = 32'h2000_0fff;
    localparam logic [31:0] ADC_BASE = 32'h4002_0800;
    localparam logic [31:0] ADC_LAST = 32'h4002_0bff;
    localparam logic [31:0] APB_BASE = 32'h4000_0000;
    localparam logic [31:0] APB_LAST = 32'h4000_73ff;
    localparam logic [31:0] AHB_BASE = 32'h4002_0000;
    localparam logic [31:0] AHB_LAST = 32'h4002_33ff;
    localparam int SLOT_SHIFT = 10;

    // apb slot occupancy, one bit per 1KB window from APB_BASE
    localparam logic [31:0] APB_SLOT_USED = 32'h1066_6bba;
    // ahb windows: rcc, flash regs, crc
    localparam logic [31:0] RCC_BASE = 32'h4002_1000;
    localparam logic [31:0] RCC_LAST = 32'h4002_13ff;
    localparam logic [31:0] FREG_BASE = 32'h4002_2000;
    localparam logic [31:0] FREG_LAST = 32'h4002_23ff;
    localparam logic [31:0] CRC_BASE = 32'h4002_3000;
    localparam logic [31:0] CRC_LAST = 32'h4002_33ff;

    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic HRESP_ERROR = 1'b1;

    localparam int PCLK_MAX_MHZ = 48;
    localparam int SYSCLK_MHZ = 125;
    localparam int PCLK_DIV = (SYSCLK_MHZ + PCLK_MAX_MHZ - 1) / PCLK_MAX_MHZ;
endpackage

// File: matrix_decoder.sv
`timescale 1ns/100ps
module matrix_decoder
    import bus_matrix_pkg::*;
(
    input  wire logic [31:0]            addr,
    output logic      [NUM_SLAVES-1:0] select,
    output logic      [31:0]            mappedAddr,
    output logic                        apbSlotHit,
    output logic      [3:0]             apbSlot
);
    logic [4:0] slotIdx;
    logic [3:0] rank;

    always_comb
    begin
        select = '0;
        mappedAddr = addr;
        slotIdx = addr[14:10];
        apbSlotHit = 1'b0;
        apbSlot = 4'h0;
        rank = 4'h0;
        // slot number is the rank among occupied windows, so the fifteen occupied windows get distinct ids 0 to 14
        for (int i = 0; i < 32; i++)
        begin
            if (i < int'(slotIdx) && APB_SLOT_USED[i])
                rank = rank + 4'h1;
        end
        if (addr >= BOOT_BASE && addr <= BOOT_LAST)
        begin
            select[PORT_FLASH] = 1'b1;
            mappedAddr = addr | FLASH_BASE;
        end
        else if ((addr >= FLASH_BASE && addr <= FLASH_LAST)
                 || (addr >= INFO_BASE && addr <= INFO_LAST))
            select[PORT_FLASH] = 1'b1;
        else if (addr >= SRAM_BASE && addr <= SRAM_LAST)
            select[PORT_SRAM] = 1'b1;
        else if (addr >= ADC_BASE && addr <= ADC_LAST)
            select[PORT_ADC] = 1'b1;
        else if ((addr >= RCC_BASE && addr <= RCC_LAST)
                 || (addr >= FREG_BASE && addr <= FREG_LAST)
                 || (addr >= CRC_BASE && addr <= CRC_LAST))
            select[PORT_AHB] = 1'b1;
        else if (addr >= APB_BASE && addr <= APB_LAST && APB_SLOT_USED[slotIdx])
        begin
            select[PORT_APB] = 1'b1;
            apbSlotHit = 1'b1;
            apbSlot = rank;
        end
    end
endmodule

// File: system_bus_matrix.sv
`timescale 1ns/100ps
module system_bus_matrix
    import bus_matrix_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // master side (processor system bus)
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    output logic      [31:0]              hrdata,
    output logic                          hready,
    output logic                          hresp,
    // shared slave-side address phase, plus data-phase write data and peripheral clock enable
    output logic      [31:0]              slvAddr,
    output logic      [1:0]               slvTrans,
    output logic                          slvWrite,
    output logic      [2:0]               slvSize,
    output logic      [3:0]               slvByteEn,
    output logic      [31:0]              slvWdata,
    output logic      [NUM_SLAVES-1:0]    slvSel,
    output logic      [3:0]               apbSlot,
    output logic                          pclkEnable,
    // slave answers
    input  wire logic [NUM_SLAVES*32-1:0] slvRdata,
    input  wire logic [NUM_SLAVES-1:0]    slvReady,
    input  wire logic [NUM_SLAVES-1:0]    slvResp
);
    typedef enum logic [1:0] {IDLE, DATA, ERR1, ERR2} phase_e;

    phase_e                  phase;
    logic [NUM_SLAVES-1:0]   decSel;
    logic [NUM_SLAVES-1:0]   dataSel;
    logic [31:0]             decAddr;
    logic                    decSlotHit;
    logic [3:0]              decSlot;
    logic                    reqValid;
    logic                    grant;
    logic [1:0]              addrLow;
    logic [31:0]             pickRdata;
    logic                    pickReady;
    logic                    pickResp;
    logic [7:0]              pclkCount;

    matrix_decoder u_dec
    (
        .addr       (haddr),
        .select     (decSel),
        .mappedAddr (decAddr),
        .apbSlotHit (decSlotHit),
        .apbSlot    (decSlot)
    );

    assign reqValid = (htrans == HTRANS_NSEQ) || (htrans == HTRANS_SEQ);
    // single master: grant whenever the data phase is free, still one arbitration point
    assign grant = reqValid && hready;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            phase <= IDLE;
        else if (hready && grant && decSel == '0)
            phase <= ERR1;
        else if (phase == ERR1)
            phase <= ERR2;
        else if (hready)
            phase <= grant ? DATA : IDLE;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dataSel <= '0;
            addrLow <= 2'h0;
        end
        else if (hready)
        begin
            dataSel <= grant ? decSel : '0;
            addrLow <= haddr[1:0];
        end
    end

    // address phase forwarded with the boot alias applied
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slvAddr <= 32'h0000_0000;
            slvTrans <= HTRANS_IDLE;
            slvWrite <= 1'b0;
            slvSize <= 3'h0;
            slvByteEn <= 4'h0;
            slvSel <= '0;
            apbSlot <= 4'h0;
        end
        else if (hready)
        begin
            slvAddr <= decAddr;
            slvTrans <= grant ? htrans : HTRANS_IDLE;
            slvWrite <= hwrite;
            slvSize <= hsize;
            slvSel <= grant ? decSel : '0;
            apbSlot <= decSlotHit ? decSlot : 4'h0;
            // lane 0 carries the lowest-addressed byte
            case (hsize)
                3'h0: slvByteEn <= 4'h1 << haddr[1:0];
                3'h1: slvByteEn <= haddr[1] ? 4'hc : 4'h3;
                default: slvByteEn <= 4'hf;
            endcase
        end
    end

    // write data belongs to the data phase, one cycle behind
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            slvWdata <= 32'h0000_0000;
        else
            slvWdata <= hwdata;
    end

    always_comb
    begin
        pickRdata = 32'h0000_0000;
        pickReady = 1'b1;
        pickResp = HRESP_OKAY;
        for (int i = 0; i < NUM_SLAVES; i++)
        begin
            if (dataSel[i])
            begin
                pickRdata = slvRdata[i*32 +: 32];
                pickReady = slvReady[i];
                pickResp = slvResp[i];
            end
        end
    end

    // two-cycle error answer as the bus protocol requires
    always_comb
    begin
        hrdata = pickRdata;
        case (phase)
            ERR1:
            begin
                hready = 1'b0;
                hresp = HRESP_ERROR;
            end
            ERR2:
            begin
                hready = 1'b1;
                hresp = HRESP_ERROR;
            end
            DATA:
            begin
                hready = pickReady;
                hresp = pickResp;
            end
            default:
            begin
                hready = 1'b1;
                hresp = HRESP_OKAY;
            end
        endcase
    end

    // peripheral clock enable kept at or below its ceiling
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pclkCount <= 8'h00;
            pclkEnable <= 1'b0;
        end
        else if (pclkCount == 8'(PCLK_DIV - 1))
        begin
            pclkCount <= 8'h00;
            pclkEnable <= 1'b1;
        end
        else
        begin
            pclkCount <= pclkCount + 8'h01;
            pclkEnable <= 1'b0;
        end
    end
endmodule

// File: system_bus_matrix_asserts.sv
`timescale 1ns/100ps
module system_bus_matrix_asserts
    import bus_matrix_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  sys_rst,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic [2:0]            hsize,
    input wire logic                  hready,
    input wire logic                  hresp,
    input wire logic [31:0]           slvAddr,
    input wire logic [3:0]            slvByteEn,
    input wire logic [NUM_SLAVES-1:0] slvSel,
    input wire logic [3:0]            apbSlot,
    input wire logic                  pclkEnable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // taken request: active transfer while the bus is ready
    wire req = htrans[1] && hready;
    chk_boot_alias: assert property (
        req && haddr <= BOOT_LAST |=> slvSel == 5'h01 && slvAddr == (FLASH_BASE | $past(haddr)))
        else $error("boot alias not routed to flash");
    chk_flash_direct: assert property (
        req && haddr >= FLASH_BASE && haddr <= FLASH_LAST |=> slvSel == 5'h01 && slvAddr == $past(haddr))
        else $error("flash region not routed to flash");
    chk_sram_route: assert property (
        req && haddr[31:12] == 20'h20000 |=> slvSel == 5'h02)
        else $error("sram region not routed to sram");
    chk_apb_slot: assert property (
        req && haddr[31:10] == 22'h100001 |=> slvSel == 5'h10 && apbSlot == 4'h0)
        else $error("apb slot one wrongly decoded");
    chk_reserved_error: assert property (
        req && haddr[31:28] == 4'h6 |=> slvSel == 5'h00 && !hready && hresp ##1 hready && hresp)
        else $error("reserved region missing two-cycle error");
    chk_byte_lane: assert property (
        req && hsize == 3'h0 |=> slvByteEn == 4'h1 << $past(haddr[1:0]))
        else $error("byte lane wrong");
    chk_half_lanes: assert property (
        req && hsize == 3'h1 |=> slvByteEn == ($past(haddr[1]) ? 4'hc : 4'h3))
        else $error("halfword lanes wrong");
    chk_pclk_spacing: assert property (
        pclkEnable |=> !pclkEnable [*2] ##1 pclkEnable)
        else $error("peripheral clock enable not every third cycle");
    cover property (req && haddr == 32'h0000_0004);
    cover property (req && haddr[31:28] == 4'h6);
    cover property (req && hsize == 3'h1);
endmodule
bind system_bus_matrix system_bus_matrix_asserts u_system_bus_matrix_asserts (
    .clock(clock), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans), .hsize(hsize),
    .hready(hready), .hresp(hresp), .slvAddr(slvAddr), .slvByteEn(slvByteEn),
    .slvSel(slvSel), .apbSlot(apbSlot), .pclkEnable(pclkEnable));

// File: ahb_master_model.sv
`timescale 1ns/100ps
module ahb_master_model
    import bus_matrix_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        hready,
    input  wire logic        hresp,
    input  wire logic [31:0] hrdata,
    output logic      [31:0] haddr = 32'h0,
    output logic      [1:0]  htrans = HTRANS_IDLE,
    output logic             hwrite = 1'b0,
    output logic      [2:0]  hsize = 3'h2,
    output logic      [31:0] hwdata = 32'h0
);
    logic timedOut = 1'b0;
    // hready looked at mid-cycle, where it stands for the coming rising edge
    task automatic waitReady();
        int n = 0;
        while (hready !== 1'b1 && n < 64)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 64)
            timedOut = 1'b1;
    endtask
    // no pipelining: simpler, but back-to-back overlap stays unexercised
    task automatic xfer(input logic [31:0] a, input logic [2:0] sz, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd, output logic rsp);
        @(negedge clock);
        haddr = a;
        htrans = HTRANS_NSEQ;
        hwrite = wr;
        hsize = sz;
        hwdata = ~hwdata;
        waitReady();
        @(posedge clock);
        @(negedge clock);
        htrans = HTRANS_IDLE;
        hwdata = wd;
        waitReady();
        rd = hrdata;
        rsp = hresp;
        @(posedge clock);
        @(negedge clock);
    endtask
endmodule

// File: system_bus_matrix_tb.sv
`timescale 1ns/100ps
module system_bus_matrix_tb import bus_matrix_pkg::*;;
    logic                     clock = 1'b0;
    logic                     sys_rst = 1'b1;
    logic [31:0]              haddr, hwdata, hrdata, slvAddr, slvWdata, rd;
    logic [1:0]               htrans, slvTrans;
    logic [2:0]               hsize, slvSize;
    logic                     hwrite, hready, hresp, slvWrite, pclkEnable, rsp;
    logic [3:0]               slvByteEn, apbSlot;
    logic [NUM_SLAVES-1:0]    slvSel;
    logic [NUM_SLAVES-1:0]    slvResp = 5'h00;
    logic [NUM_SLAVES-1:0]    slvReady = 5'h1f;
    logic [NUM_SLAVES*32-1:0] slvRdata = {32'hc0de_0004, 32'hc0de_0003, 32'hc0de_0002,
                                          32'hc0de_0001, 32'hc0de_0000};
    int                       failures = 0;
    int                       comparisons = 0;
    system_bus_matrix u_system_bus_matrix (.clock(clock), .sys_rst(sys_rst), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hready(hready), .hresp(hresp), .slvAddr(slvAddr), .slvTrans(slvTrans),
        .slvWrite(slvWrite), .slvSize(slvSize), .slvByteEn(slvByteEn), .slvWdata(slvWdata),
        .slvSel(slvSel), .apbSlot(apbSlot), .pclkEnable(pclkEnable), .slvRdata(slvRdata),
        .slvReady(slvReady), .slvResp(slvResp));
    ahb_master_model u_ahb_master_model (.clock(clock), .hready(hready), .hresp(hresp),
        .hrdata(hrdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    initial forever #4 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic [31:0] a, input logic [2:0] sz, input logic wr);
        u_ahb_master_model.xfer(a, sz, wr, 32'h5a5a_a5a5, rd, rsp);
    endtask
    task automatic scen_boot();
        go(32'h0000_0000, 3'h2, 1'b0);
        check(rd, 32'hc0de_0000);
        go(32'h0000_0004, 3'h2, 1'b0);
        check(rd, 32'hc0de_0000);
        go(32'h0800_0004, 3'h2, 1'b0);
        check(rd, 32'hc0de_0000);
    endtask
    task automatic scen_route();
        logic [31:0] addrs [5] = '{32'h0800_0010, 32'h2000_0010, 32'h4002_0800,
                                   32'h4002_1000, 32'h4000_0400};
        for (int i = 0; i < 5; i++)
        begin
            go(addrs[i], 3'h2, 1'b0);
            check(rd, 32'hc0de_0000 + 32'(i));
            check({31'h0, rsp}, 32'h0);
        end
    endtask
    task automatic scen_error();
        logic [31:0] addrs [3] = '{32'h6000_0000, 32'h4000_0000, 32'h4002_0000};
        for (int i = 0; i < 3; i++)
        begin
            go(addrs[i], 3'h2, 1'b0);
            check({31'h0, rsp}, 32'h1);
        end
    endtask
    task automatic scen_lanes();
        for (int i = 0; i < 6; i++)
        begin
            go(32'h2000_0000 + 32'(i % 4), (i < 4) ? 3'h0 : 3'h1, 1'b1);
            check({31'h0, rsp}, 32'h0);
            check(slvWdata, 32'h5a5a_a5a5);
            check({31'h0, slvWrite}, 32'h1);
            check({28'h0, slvByteEn}, (i < 4) ? 32'h1 << i : 32'h3);
        end
    endtask
    task automatic scen_pclk();
        int n = 0;
        repeat (30)
        begin
            @(posedge clock);
            n += int'(pclkEnable);
        end
        check(32'(n), 32'h0a);
    endtask
    task automatic end_of_test();
        failures += int'(u_ahb_master_model.timedOut);
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        scen_boot();
        scen_route();
        scen_error();
        scen_lanes();
        scen_pclk();
        end_of_test();
    end
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule
